// ---- dv/test_two_level_interrupt_controller.sv ----
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model makes boundaries and returns
// Notes: random levels, enables and requests
`timescale 1ns/1ps
`default_nettype none
module test_two_level_interrupt_controller import tlic_pkg::*; ;
	logic clk, rstn, reg_wr, reg_rd, slow, do_reti;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, pe, pl, sec, wdc;
	logic [NSRC-1:0] src_req;
	logic instr_boundary, reti_exec, pc_push, pc_load, pc_pop, event_irq;
	logic [15:0] vector_addr;
	logic [3:0] vector_src;
	logic [31:0] seed;
	bit svc [$];
	int errors, comparisons;
	int last_src;
	bit [3:0] evs;
	localparam logic [15:0] VEC [NSRC] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033,
		16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
	localparam int SP [NSRC] = '{1, 0, 0, 6, 1, 2, 3, 0, 4, 5, 2};
	localparam logic [7:0] RA [10] = '{8'ha8, 8'hb8, 8'ha9, 8'hf0, 8'hf1, 8'hf3, 8'he0,
		8'hf2, 8'hf4, 8'hf5};
	localparam logic [7:0] RV [10] = '{8'h00, 8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	tlic_top dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.src_req, .instr_boundary, .reti_exec, .pc_push, .pc_load, .pc_pop,
		.vector_addr, .vector_src, .event_irq);
	tlic_core_model core (.clk, .rstn, .slow, .do_reti, .pc_push, .pc_load, .pc_pop,
		.vector_addr, .instr_boundary, .reti_exec);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic bit gated(int s, bit hi);
		logic [7:0] e;
		logic [7:0] l;
		e = pe;
		l = pl;
		if (s == 0 || s == 7 || s == 10) begin
			e = sec;
			l = sec >> 4;
		end
		if (s == 1) begin
			e = wdc;
			l = wdc >> 1;
		end
		return pe[7] && e[SP[s]] && l[SP[s]] == hi;
	endfunction
	function automatic int predict(logic [NSRC-1:0] r, output bit lvl);
		for (int h = 1; h >= 0; h--) begin
			if (svc.size() > 0 && (h == 0 || svc[$])) continue;
			for (int s = 0; s < NSRC; s++) begin
				if (r[s] && gated(s, h)) begin
					lvl = h;
					return s;
				end
			end
		end
		return -1;
	endfunction
	task automatic check(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		case (a)
			ADDR_PRI_ENABLE: pe = d;
			ADDR_PRI_LEVEL: pl = d;
			ADDR_SEC_ENLVL: sec = d;
			ADDR_WDT_CTRL: wdc = d;
			default: ;
		endcase
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check($sformatf("reg %h", a), e, reg_rdata);
	endtask
	task automatic serve(logic [NSRC-1:0] r);
		int w;
		int n;
		bit lvl;
		w = predict(r, lvl);
		@(posedge clk);
		src_req <= r;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (pc_push !== 1'b1 && n < 12);
		check("accepted", w >= 0, pc_push);
		if (w >= 0) begin
			check("source", w, vector_src);
			check("vector", VEC[w], vector_addr);
			@(posedge clk);
			#1 check("load", 1, pc_load);
			evs[lvl ? E_TAKE_HI : E_TAKE_LO] = 1'b1;
			if (lvl && svc.size() > 0) evs[E_PREEMPT] = 1'b1;
			last_src = w;
			svc.push_back(lvl);
		end
		@(posedge clk);
		src_req <= '0;
	endtask
	task automatic ret();
		@(posedge clk);
		do_reti <= 1'b1;
		@(posedge clk);
		do_reti <= 1'b0;
		@(posedge clk);
		#1 check("pop", svc.size() > 0, pc_pop);
		if (svc.size() > 0) svc.pop_back();
	endtask
	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#500000;
		errors++;
		$display("watchdog expired");
		conclude();
	end
	initial begin
		{rstn, reg_wr, reg_rd, slow, do_reti, reg_addr, reg_wdata, src_req} = '0;
		{pe, pl, wdc, sec, seed} = {24'h0, 8'ha0, 32'd85};
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 10; i++) rd(RA[i], RV[i]);
		wr(ADDR_PRI_LEVEL, 8'hff);
		rd(ADDR_PRI_LEVEL, 8'h7f);
		wr(ADDR_SEC_ENLVL, 8'h77);
		rd(ADDR_SEC_ENLVL, 8'hf7);
		$display("register test done");
		wr(ADDR_PRI_ENABLE, 8'h7f);
		wr(ADDR_WDT_CTRL, 8'h01);
		src_req <= 11'h7ff;
		rd(ADDR_PENDING_LO, 8'hff);
		rd(ADDR_PENDING_HI, 8'h07);
		serve(11'h7ff);
		$display("global enable test done");
		for (int i = 0; i < 30; i++) begin
			slow <= 1'(rnd());
			wr(ADDR_PRI_ENABLE, 8'(rnd() | rnd()) | 8'h80);
			wr(ADDR_PRI_LEVEL, 8'(rnd()) & 8'h7f);
			wr(ADDR_SEC_ENLVL, 8'(rnd() | rnd()) & 8'h77);
			wr(ADDR_WDT_CTRL, 8'(rnd()) | 8'h01);
			serve(11'(rnd() & rnd()));
			serve(11'(rnd()));
			rd(ADDR_SVC_STATE, {4'(last_src), 2'h0, svc.size() == 2 ? 2'h3 :
				svc.size() == 0 ? 2'h0 : svc[0] ? 2'h2 : 2'h1});
			while (svc.size() > 0) ret();
		end
		$display("arbitration test done");
		rd(ADDR_EVT_STATUS, {4'h0, evs});
		wr(ADDR_EVT_STATUS, 8'h0f);
		rd(ADDR_EVT_STATUS, 8'h00);
		ret();
		rd(ADDR_EVT_STATUS, 8'h08);
		wr(ADDR_EVT_MASK, 8'h08);
		repeat (2) @(posedge clk);
		#1 check("irq set", 1, event_irq);
		wr(ADDR_EVT_STATUS, 8'h08);
		repeat (2) @(posedge clk);
		#1 check("irq clear", 0, event_irq);
		$display("event test done");
		conclude();
	end
endmodule
`default_nettype wire

// ---- dv/tlic_core_model.sv ----
// Purpose: behavioural core beside the controller
// Assumes: slow selects one boundary every two cycles
// Notes: return is issued one cycle after do_reti
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bench controls
	input wire logic slow,
	input wire logic do_reti,
	// Controller side
	input wire logic pc_push,
	input wire logic pc_load,
	input wire logic pc_pop,
	input wire logic [15:0] vector_addr,
	output logic instr_boundary,
	output logic reti_exec
);
	logic [15:0] pc;
	logic [15:0] stack [$];
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			instr_boundary <= 1'b0;
			reti_exec <= 1'b0;
		end else begin
			instr_boundary <= slow ? !instr_boundary : 1'b1;
			reti_exec <= do_reti;
		end
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc <= 16'h0100;
			stack.delete();
		end else if (pc_push) begin
			stack.push_back(pc);
		end else if (pc_load) begin
			pc <= vector_addr;
		end else if (pc_pop && stack.size() > 0) begin
			pc <= stack.pop_back();
		end else begin
			pc <= pc + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ---- dv/tlic_top_sva.sv ----
// Purpose: port checks for the interrupt controller
// Assumes: one clock, active-low asynchronous reset
// Notes: bound into every tlic_top
`timescale 1ns/1ps
`default_nettype none
module tlic_top_sva import tlic_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Requests and core
	input wire logic [NSRC-1:0] src_req,
	input wire logic instr_boundary,
	input wire logic reti_exec,
	input wire logic pc_push,
	input wire logic pc_load,
	input wire logic pc_pop,
	input wire logic [15:0] vector_addr,
	input wire logic [3:0] vector_src,
	input wire logic event_irq
);
	localparam logic [7:0] VEC [NSRC] = '{8'h43, 8'h5b, 8'h03, 8'h33, 8'h0b, 8'h13,
		8'h1b, 8'h3b, 8'h23, 8'h2b, 8'h53};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_load_follows_push: assert property (pc_push |=> pc_load && !pc_push)
		else $error("pc_load did not follow pc_push");
	chk_push_gap: assert property (pc_push |=> !pc_push ##1 !pc_push)
		else $error("accept during push or load");
	chk_push_at_boundary: assert property (pc_push |-> $past(instr_boundary))
		else $error("accept away from a boundary");
	chk_source_requested: assert property (pc_push |->
		|($past(src_req) & (11'h001 << vector_src)))
		else $error("accepted source was not requesting");
	chk_vector_table: assert property (pc_push |->
		vector_addr == {8'h00, VEC[vector_src]})
		else $error("wrong vector address");
	chk_pop_after_reti: assert property (pc_pop |-> $past(reti_exec))
		else $error("pop without return");
	chk_reti_blocks_push: assert property (reti_exec |=> !pc_push)
		else $error("accept beside a return");
	chk_sec_top_bit: assert property ($past(reg_rd) &&
		$past(reg_addr) == ADDR_SEC_ENLVL |-> reg_rdata[7])
		else $error("secondary bit 7 not one");
	chk_level_top_bit: assert property ($past(reg_rd) &&
		$past(reg_addr) == ADDR_PRI_LEVEL |-> !reg_rdata[7])
		else $error("level bit 7 not zero");
	cov_push: cover property (pc_push);
	cov_pop: cover property (pc_pop);
	cov_irq: cover property (event_irq);
endmodule
bind tlic_top tlic_top_sva u_sva (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .src_req, .instr_boundary, .reti_exec, .pc_push, .pc_load, .pc_pop,
	.vector_addr, .vector_src, .event_irq);
`default_nettype wire

// ---- rtl/tlic_arb_if.sv ----
// Purpose: carries gated requests to the arbiter and winners back
// Assumes: all signals on the controller clock
// Notes: purely combinational bundle
`timescale 1ns/1ps
`default_nettype none
interface tlic_arb_if import tlic_pkg::*; ();
	logic [NSRC-1:0] req;
	logic [NSRC-1:0] level;
	logic hi_any;
	logic [3:0] hi_src;
	logic lo_any;
	logic [3:0] lo_src;
	modport ctl (output req, output level, input hi_any, input hi_src, input lo_any, input lo_src);
	modport arb (input req, input level, output hi_any, output hi_src, output lo_any, output lo_src);
endinterface
`default_nettype wire

// ---- rtl/tlic_arbiter.sv ----
// Purpose: picks the first requesting source of each level
// Assumes: requests already gated by their enables
// Notes: bit 0 of the request vector polls first
`timescale 1ns/1ps
`default_nettype none
module tlic_arbiter import tlic_pkg::*; (
	// Arbitration bundle
	tlic_arb_if.arb arb
);
	logic [NSRC-1:0] hi_req;
	logic [NSRC-1:0] lo_req;

	function automatic logic [3:0] first_src(input logic [NSRC-1:0] v);
		first_src = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_src = 4'(i);
			end
		end
	endfunction

	assign hi_req = arb.req & arb.level;
	assign lo_req = arb.req & ~arb.level;
	assign arb.hi_any = |hi_req;
	assign arb.lo_any = |lo_req;
	assign arb.hi_src = first_src(hi_req);
	assign arb.lo_src = first_src(lo_req);
endmodule
`default_nettype wire

// ---- rtl/tlic_pkg.sv ----
// Purpose: constants for the two-level interrupt controller
// Assumes: 8-bit special function register port, 11 request sources
// Notes: source numbers follow the fixed polling order, 0 polls first
// Contract
// - The primary level register holds converter 6, timer 2 5, UART 4, timer 1 3, ext 1 2, timer 0 1, ext 0 0, where 1 means high.
// - The secondary register holds level bits for interval counter 6, supply monitor 5 and serial interface 4, where 1 means high.
// - The secondary register holds enable bits for interval counter 2, supply monitor 1 and serial interface 0.
// - Bit 7 of the primary level register and of the secondary register is not implemented and ignores writes.
// - An enabled high-level request preempts a running low-level routine at once.
// - When both levels request together, the high-level request is taken first.
// - A request never preempts a routine of its own level and waits for that routine to return.
// - Same-level requests are polled in the fixed order supply monitor, watchdog, ext 0, converter, timer 0, ext 1, timer 1, serial, UART, timer 2, interval counter.
// - On acceptance the core pushes the program counter and then loads the chosen vector.
// - Vectors are ext 0 0003, timer 0 000b, ext 1 0013, timer 1 001b, UART 0023, timer 2 002b, converter 0033, serial 003b, supply 0043, interval 0053, watchdog 005b.
// - A global enable bit gates every source, and when clear nothing is accepted.
// - The primary enable register holds one enable per primary source at the same positions as its level bit.
package tlic_pkg;
	localparam int NSRC = 11;
	// Register addresses
	localparam logic [7:0] ADDR_PRI_ENABLE = 8'ha8;
	localparam logic [7:0] ADDR_SEC_ENLVL = 8'ha9;
	localparam logic [7:0] ADDR_PRI_LEVEL = 8'hb8;
	localparam logic [7:0] ADDR_EVT_STATUS = 8'hf0;
	localparam logic [7:0] ADDR_EVT_MASK = 8'hf1;
	localparam logic [7:0] ADDR_SVC_STATE = 8'hf2;
	localparam logic [7:0] ADDR_WDT_CTRL = 8'hf3;
	localparam logic [7:0] ADDR_PENDING_LO = 8'hf4;
	localparam logic [7:0] ADDR_PENDING_HI = 8'hf5;
	// Reset values
	localparam logic [7:0] RST_PRI_ENABLE = 8'h00;
	localparam logic [7:0] RST_PRI_LEVEL = 8'h00;
	localparam logic [7:0] RST_SEC_ENLVL = 8'ha0;
	localparam logic [7:0] RST_EVT_MASK = 8'h00;
	localparam logic [1:0] RST_WDT_CTRL = 2'h0;
	// Primary enable and level field positions
	localparam int B_GLOBAL = 7;
	localparam int B_CONV = 6;
	localparam int B_TMR2 = 5;
	localparam int B_UART = 4;
	localparam int B_TMR1 = 3;
	localparam int B_EXT1 = 2;
	localparam int B_TMR0 = 1;
	localparam int B_EXT0 = 0;
	// Secondary register field positions
	localparam int B_UNIMPL = 7;
	localparam int B_TIC_LVL = 6;
	localparam int B_PSM_LVL = 5;
	localparam int B_SER_LVL = 4;
	localparam int B_TIC_EN = 2;
	localparam int B_PSM_EN = 1;
	localparam int B_SER_EN = 0;
	// Watchdog control fields
	localparam int B_WDT_EN = 0;
	localparam int B_WDT_LVL = 1;
	// Event status fields
	localparam int NEVT = 4;
	localparam int E_TAKE_LO = 0;
	localparam int E_TAKE_HI = 1;
	localparam int E_PREEMPT = 2;
	localparam int E_STRAY_RET = 3;
	// Source numbers in polling order
	localparam logic [3:0] S_PSM = 4'h0;
	localparam logic [3:0] S_WDT = 4'h1;
	localparam logic [3:0] S_EXT0 = 4'h2;
	localparam logic [3:0] S_CONV = 4'h3;
	localparam logic [3:0] S_TMR0 = 4'h4;
	localparam logic [3:0] S_EXT1 = 4'h5;
	localparam logic [3:0] S_TMR1 = 4'h6;
	localparam logic [3:0] S_SER = 4'h7;
	localparam logic [3:0] S_UART = 4'h8;
	localparam logic [3:0] S_TMR2 = 4'h9;
	localparam logic [3:0] S_TIC = 4'ha;

	typedef enum logic [1:0] {
		SVC_IDLE = 2'h0,
		SVC_LOW = 2'h1,
		SVC_NEST = 2'h3,
		SVC_HIGH = 2'h2
	} tlic_svc_t;

	function automatic logic [15:0] tlic_vector(input logic [3:0] src);
		case (src)
			S_PSM: tlic_vector = 16'h0043;
			S_WDT: tlic_vector = 16'h005b;
			S_EXT0: tlic_vector = 16'h0003;
			S_CONV: tlic_vector = 16'h0033;
			S_TMR0: tlic_vector = 16'h000b;
			S_EXT1: tlic_vector = 16'h0013;
			S_TMR1: tlic_vector = 16'h001b;
			S_SER: tlic_vector = 16'h003b;
			S_UART: tlic_vector = 16'h0023;
			S_TMR2: tlic_vector = 16'h002b;
			S_TIC: tlic_vector = 16'h0053;
			default: tlic_vector = 16'h0000;
		endcase
	endfunction
endpackage

// ---- rtl/tlic_top.sv ----
// Purpose: two-level interrupt controller beside a single-cycle core
// Assumes: request flags and core strobes come from logic on clk
// Notes: vector load follows the push by one cycle
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tlic_top import tlic_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Peripheral request flags, polling order
	input wire logic [NSRC-1:0] src_req,
	// Core handshake
	input wire logic instr_boundary,
	input wire logic reti_exec,
	output logic pc_push,
	output logic pc_load,
	output logic pc_pop,
	output logic [15:0] vector_addr,
	output logic [3:0] vector_src,
	// Event interrupt
	output logic event_irq
);
	tlic_arb_if arb_bus ();

	// Software visible registers
	logic [7:0] pri_enable;
	logic [6:0] pri_level;
	logic [6:0] sec_enlvl;
	logic [1:0] wdt_ctrl;
	logic [NEVT-1:0] evt_status;
	logic [NEVT-1:0] evt_mask;

	// Service tracking
	tlic_svc_t svc_state;
	tlic_svc_t next_svc_state;

	// Acceptance path
	logic [NSRC-1:0] src_enable;
	logic [NSRC-1:0] src_level;
	logic global_en;
	logic busy;
	logic may_arb;
	logic accept_hi;
	logic accept_lo;
	logic accept;
	logic [3:0] accept_src;
	logic stray_ret;
	logic [NEVT-1:0] evt_set;

	// Register decode
	logic wr_pri_enable;
	logic wr_pri_level;
	logic wr_sec_enlvl;
	logic wr_wdt_ctrl;
	logic wr_evt_status;
	logic wr_evt_mask;
	logic [7:0] next_rdata;

	assign global_en = pri_enable[B_GLOBAL];

	// Per-source enables in polling order
	always_comb begin
		src_enable = '0;
		src_enable[S_PSM] = sec_enlvl[B_PSM_EN];
		src_enable[S_WDT] = wdt_ctrl[B_WDT_EN];
		src_enable[S_EXT0] = pri_enable[B_EXT0];
		src_enable[S_CONV] = pri_enable[B_CONV];
		src_enable[S_TMR0] = pri_enable[B_TMR0];
		src_enable[S_EXT1] = pri_enable[B_EXT1];
		src_enable[S_TMR1] = pri_enable[B_TMR1];
		src_enable[S_SER] = sec_enlvl[B_SER_EN];
		src_enable[S_UART] = pri_enable[B_UART];
		src_enable[S_TMR2] = pri_enable[B_TMR2];
		src_enable[S_TIC] = sec_enlvl[B_TIC_EN];
	end

	// Per-source levels, 1 selects high
	always_comb begin
		src_level = '0;
		src_level[S_PSM] = sec_enlvl[B_PSM_LVL];
		src_level[S_WDT] = wdt_ctrl[B_WDT_LVL];
		src_level[S_EXT0] = pri_level[B_EXT0];
		src_level[S_CONV] = pri_level[B_CONV];
		src_level[S_TMR0] = pri_level[B_TMR0];
		src_level[S_EXT1] = pri_level[B_EXT1];
		src_level[S_TMR1] = pri_level[B_TMR1];
		src_level[S_SER] = sec_enlvl[B_SER_LVL];
		src_level[S_UART] = pri_level[B_UART];
		src_level[S_TMR2] = pri_level[B_TMR2];
		src_level[S_TIC] = sec_enlvl[B_TIC_LVL];
	end

	assign arb_bus.req = src_req & src_enable;
	assign arb_bus.level = src_level;

	tlic_arbiter u_arbiter (
		.arb(arb_bus)
	);

	// No new vector while one is being delivered
	assign busy = pc_push | pc_load;

	// A return in the same cycle wins over arbitration
	assign may_arb = instr_boundary & global_en & ~busy & ~reti_exec;

	// High enters from idle or low; low only from idle, never ahead of high
	always_comb begin
		accept_hi = 1'b0;
		accept_lo = 1'b0;
		case (svc_state)
			SVC_IDLE: begin
				accept_hi = may_arb & arb_bus.hi_any;
				accept_lo = may_arb & arb_bus.lo_any & ~arb_bus.hi_any;
			end
			SVC_LOW: begin
				accept_hi = may_arb & arb_bus.hi_any;
				accept_lo = 1'b0;
			end
			SVC_NEST, SVC_HIGH: begin
				accept_hi = 1'b0;
				accept_lo = 1'b0;
			end
			default: begin
				accept_hi = 1'b0;
				accept_lo = 1'b0;
			end
		endcase
	end

	assign accept = accept_hi | accept_lo;
	assign accept_src = accept_hi ? arb_bus.hi_src : arb_bus.lo_src;
	assign stray_ret = reti_exec & (svc_state == SVC_IDLE);

	// Service level tracking
	always_comb begin
		next_svc_state = svc_state;
		case (svc_state)
			SVC_IDLE: begin
				if (accept_hi) begin
					next_svc_state = SVC_HIGH;
				end else if (accept_lo) begin
					next_svc_state = SVC_LOW;
				end
			end
			SVC_LOW: begin
				if (reti_exec) begin
					next_svc_state = SVC_IDLE;
				end else if (accept_hi) begin
					next_svc_state = SVC_NEST;
				end
			end
			SVC_NEST: begin
				if (reti_exec) begin
					next_svc_state = SVC_LOW;
				end
			end
			SVC_HIGH: begin
				if (reti_exec) begin
					next_svc_state = SVC_IDLE;
				end
			end
			default: begin
				next_svc_state = SVC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			svc_state <= SVC_IDLE;
		end else begin
			svc_state <= next_svc_state;
		end
	end

	// Push first, then load the vector a cycle later
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_push <= 1'b0;
			pc_load <= 1'b0;
		end else begin
			pc_push <= accept;
			pc_load <= pc_push;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vector_addr <= 16'h0000;
			vector_src <= 4'h0;
		end else if (accept) begin
			vector_addr <= tlic_vector(accept_src);
			vector_src <= accept_src;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_pop <= 1'b0;
		end else begin
			pc_pop <= reti_exec & (svc_state != SVC_IDLE);
		end
	end

	// Register write decode
	function automatic logic wr_hit(
		input logic wr,
		input logic [7:0] addr,
		input logic [7:0] reg_at
	);
		wr_hit = wr & (addr == reg_at);
	endfunction

	assign wr_pri_enable = wr_hit(reg_wr, reg_addr, ADDR_PRI_ENABLE);
	assign wr_pri_level = wr_hit(reg_wr, reg_addr, ADDR_PRI_LEVEL);
	assign wr_sec_enlvl = wr_hit(reg_wr, reg_addr, ADDR_SEC_ENLVL);
	assign wr_wdt_ctrl = wr_hit(reg_wr, reg_addr, ADDR_WDT_CTRL);
	assign wr_evt_status = wr_hit(reg_wr, reg_addr, ADDR_EVT_STATUS);
	assign wr_evt_mask = wr_hit(reg_wr, reg_addr, ADDR_EVT_MASK);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pri_enable <= RST_PRI_ENABLE;
		end else if (wr_pri_enable) begin
			pri_enable <= reg_wdata;
		end
	end

	// Bit 7 has no storage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pri_level <= RST_PRI_LEVEL[6:0];
		end else if (wr_pri_level) begin
			pri_level <= reg_wdata[6:0];
		end
	end

	// Bit 3 is stored as written; software keeps it zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sec_enlvl <= RST_SEC_ENLVL[6:0];
		end else if (wr_sec_enlvl) begin
			sec_enlvl <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdt_ctrl <= RST_WDT_CTRL;
		end else if (wr_wdt_ctrl) begin
			wdt_ctrl <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			evt_mask <= RST_EVT_MASK[NEVT-1:0];
		end else if (wr_evt_mask) begin
			evt_mask <= reg_wdata[NEVT-1:0];
		end
	end

	// Controller events
	always_comb begin
		evt_set = '0;
		evt_set[E_TAKE_LO] = accept_lo;
		evt_set[E_TAKE_HI] = accept_hi;
		evt_set[E_PREEMPT] = accept_hi & (svc_state == SVC_LOW);
		evt_set[E_STRAY_RET] = stray_ret;
	end

	// Write one to clear; a new event wins over the clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			evt_status <= '0;
		end else if (wr_evt_status) begin
			evt_status <= (evt_status & ~reg_wdata[NEVT-1:0]) | evt_set;
		end else begin
			evt_status <= evt_status | evt_set;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			event_irq <= 1'b0;
		end else begin
			event_irq <= |(evt_status & evt_mask);
		end
	end

	// Event registers sit in the low bits
	function automatic logic [7:0] evt_word(input logic [NEVT-1:0] v);
		evt_word = {{(8 - NEVT){1'b0}}, v};
	endfunction

	// Read data mux, unmapped addresses read zero
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			ADDR_PRI_ENABLE: begin
				next_rdata = pri_enable;
			end
			ADDR_PRI_LEVEL: begin
				next_rdata = {1'b0, pri_level};
			end
			ADDR_SEC_ENLVL: begin
				next_rdata = {RST_SEC_ENLVL[B_UNIMPL], sec_enlvl};
			end
			ADDR_EVT_STATUS: begin
				next_rdata = evt_word(evt_status);
			end
			ADDR_EVT_MASK: begin
				next_rdata = evt_word(evt_mask);
			end
			ADDR_SVC_STATE: begin
				next_rdata = {vector_src, busy, 1'b0, svc_state};
			end
			ADDR_WDT_CTRL: begin
				next_rdata = {6'h00, wdt_ctrl};
			end
			ADDR_PENDING_LO: begin
				next_rdata = arb_bus.req[7:0];
			end
			ADDR_PENDING_HI: begin
				next_rdata = {5'h00, arb_bus.req[NSRC-1:8]};
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire
